/* rtl/ref_offset_store.v */
// offset word holder: loads calibration at reset release, then software writable
`timescale 1ns/1ps
module ref_offset_store #(
    parameter WIDTH = 10
) (
    input wire clk_sys_i, // system clock
    input wire reset_n_i, // async reset, active low
    input wire [WIDTH-1:0] cal_word_i, // calibration word from nonvolatile storage
    input wire wr_high_i, // write strobe, high byte
    input wire wr_low_i, // write strobe, low byte
    input wire [7:0] wdata_i, // write data
    output reg [WIDTH-1:0] word_o // stored offset word
);

    reg loaded_ff;

    // async reset takes a constant; the strap-like calibration value is caught on the
    // first clock after release
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            loaded_ff <= 1'b0;
            word_o <= {WIDTH{1'b0}};
        end else if (!loaded_ff) begin
            loaded_ff <= 1'b1;
            word_o <= cal_word_i;
        end else begin
            if (wr_high_i) begin
                word_o[WIDTH-1:WIDTH-8] <= wdata_i;
            end
            if (wr_low_i) begin
                word_o[1:0] <= wdata_i[7:6];
            end
        end
    end

endmodule

/* rtl/ref_regulator_ctrl_regs.v */
// analog support register bank: temperature offset, ADC reference, core regulator
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "ref_regulator_defs.vh"
module ref_regulator_ctrl_regs (
    input wire clk_sys_i, // system clock, 40 MHz
    input wire reset_n_i, // async reset, active low
    input wire [7:0] avs_address_i, // Avalon byte address
    input wire avs_read_i, // Avalon read
    input wire avs_write_i, // Avalon write
    input wire [7:0] avs_writedata_i, // Avalon write data
    input wire [9:0] cal_word_i, // production offset word (zero-degree reading)
    input wire stop_mode_i, // core is in STOP mode
    output reg [7:0] avs_readdata_o, // Avalon read data
    output reg avs_waitrequest_o, // Avalon wait request
    output reg [1:0] ref_source_o, // reference mux selector
    output reg sensor_enable_o, // temperature sensor power
    output reg regulator_bypass_o, // regulator in bypass
    output reg regulator_off_o, // regulator and power network shut down
    output reg mem_power_ctrl_o, // memory power controller enable
    output reg [9:0] temp_offset_word_o // offset word, left-justified
);

    ////////////////////////////////////////////////////////////////////////////
    reg [7:0] reference_control_ff;
    reg [7:0] regulator_control_ff;
    reg ack_ff;
    wire [9:0] offset_word;
    wire req;
    wire wr_take;
    wire wr_high;
    wire wr_low;
    reg [7:0] nxt_rdata;
    reg [1:0] nxt_ref_source;

    // one wait cycle per access: waitrequest drops the cycle after the request appears
    assign req = (avs_read_i | avs_write_i) & ~ack_ff;
    assign wr_take = avs_write_i & ack_ff;
    assign wr_high = wr_take & (avs_address_i == `ADDR_TEMP_OFFSET_HIGH);
    assign wr_low = wr_take & (avs_address_i == `ADDR_TEMP_OFFSET_LOW);

    ////////////////////////////////////////////////////////////////////////////
    // offset word; reading at 0 C with internal reference, stored left-justified
    ref_offset_store #(
        .WIDTH(10)
    ) u_offset (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .cal_word_i(cal_word_i),
        .wr_high_i(wr_high),
        .wr_low_i(wr_low),
        .wdata_i(avs_writedata_i),
        .word_o(offset_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    always @* begin
        case (avs_address_i)
            `ADDR_TEMP_OFFSET_HIGH: nxt_rdata = offset_word[9:2];
            `ADDR_TEMP_OFFSET_LOW: nxt_rdata = {offset_word[1:0], 6'h00};
            `ADDR_REFERENCE_CONTROL: nxt_rdata = reference_control_ff;
            `ADDR_REGULATOR_CONTROL: nxt_rdata = regulator_control_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    always @* begin
        if (reference_control_ff[`BIT_REGULATOR_REF_OVERRIDE]) begin
            nxt_ref_source = `REFSRC_REGULATOR;
        end else if (reference_control_ff[`BIT_REFERENCE_SELECT]) begin
            nxt_ref_source = `REFSRC_SUPPLY;
        end else begin
            nxt_ref_source = `REFSRC_PIN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_ff <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 8'h00;
            reference_control_ff <= `REF_CONTROL_RESET;
            regulator_control_ff <= `REG_CONTROL_RESET;
        end else begin
            ack_ff <= req;
            avs_waitrequest_o <= ~req;
            if (req & avs_read_i) begin
                avs_readdata_o <= nxt_rdata;
            end
            if (wr_take & (avs_address_i == `ADDR_REFERENCE_CONTROL)) begin
                reference_control_ff <= avs_writedata_i & `REF_CONTROL_WMASK;
            end
            // reserved bits 5:1 stay read/write storage as the register defines them
            if (wr_take & (avs_address_i == `ADDR_REGULATOR_CONTROL)) begin
                regulator_control_ff <= avs_writedata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs registered; analog controls change one cycle after the register write
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_source_o <= `REFSRC_PIN;
            sensor_enable_o <= 1'b0;
            regulator_bypass_o <= 1'b0;
            regulator_off_o <= 1'b0;
            mem_power_ctrl_o <= 1'b0;
            temp_offset_word_o <= 10'h000;
        end else begin
            ref_source_o <= nxt_ref_source;
            sensor_enable_o <= reference_control_ff[`BIT_SENSOR_ENABLE];
            regulator_bypass_o <= regulator_control_ff[`BIT_BYPASS];
            // stop configuration clear keeps the regulator alive so any reset ends STOP
            regulator_off_o <= stop_mode_i &
                regulator_control_ff[`BIT_STOP_CONFIGURATION];
            mem_power_ctrl_o <= regulator_control_ff[`BIT_MEM_POWER_CTRL];
            temp_offset_word_o <= offset_word;
        end
    end

endmodule

/* shared/ref_regulator_defs.vh */
// register offsets, field positions and reset values of the reference/regulator bank
//
// Contract
// - offset word bits 9:2 in high byte, bits 1:0 in low byte bits 7:6.
// - offset word is zero-degree ADC reading, internal reference, left-justified.
// - low byte bits 5:0 read zero, writes there ignored.
// - offset registers reset to a per-device production-measured value; here reset loads zero and the value is taken on the first clock after release.
// - override clear: select bit 3 picks pin (0) or supply (1).
// - override bit 4 set routes internal regulator as reference.
// - sensor powered only while enable bit 2 is one.
// - reference control bits 7:5 and 1:0 read zero, writes dropped.
// - stop configuration clear keeps regulator running in STOP.
// - stop configuration set shuts regulator and power network in STOP.
// - bypass bit set places regulator in bypass mode.
// - regulator control at 0xC7, reset zero, stop configuration bit 7.
// - regulator control bit 6 is bypass control.
`ifndef REF_REGULATOR_DEFS_VH
`define REF_REGULATOR_DEFS_VH

`define ADDR_TEMP_OFFSET_LOW 8'h85
`define ADDR_TEMP_OFFSET_HIGH 8'h86
`define ADDR_REGULATOR_CONTROL 8'hC7
`define ADDR_REFERENCE_CONTROL 8'hD1

`define BIT_REGULATOR_REF_OVERRIDE 4
`define BIT_REFERENCE_SELECT 3
`define BIT_SENSOR_ENABLE 2
`define BIT_STOP_CONFIGURATION 7
`define BIT_BYPASS 6
`define BIT_MEM_POWER_CTRL 0

`define REF_CONTROL_WMASK 8'h1C
`define REF_CONTROL_RESET 8'h00
`define REG_CONTROL_RESET 8'h00
`define TEMP_LOW_WMASK 8'hC0

`define REFSRC_PIN 2'h0
`define REFSRC_SUPPLY 2'h1
`define REFSRC_REGULATOR 2'h2

`endif

/* tb/ref_regulator_ctrl_props.sv */
// assertions on the reference and regulator register bank ports
`timescale 1ns/1ps
module ref_regulator_ctrl_props (
    input wire clk_sys_i, input wire reset_n_i, input wire [7:0] avs_address_i,
    input wire avs_read_i, input wire avs_write_i, input wire [7:0] avs_writedata_i,
    input wire [9:0] cal_word_i, input wire stop_mode_i, input wire [7:0] avs_readdata_o,
    input wire avs_waitrequest_o, input wire [1:0] ref_source_o, input wire sensor_enable_o,
    input wire regulator_bypass_o, input wire regulator_off_o, input wire mem_power_ctrl_o,
    input wire [9:0] temp_offset_word_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    wire wr_ok = avs_write_i && !avs_waitrequest_o;
    wire rd_ok = avs_read_i && !avs_waitrequest_o;
    reg [7:0] wd_ff;
    always @(posedge clk_sys_i) if (wr_ok) wd_ff <= avs_writedata_i;
////////////////////////////////////////
    a_src_decode: assert property (wr_ok && avs_address_i == 8'hD1 |-> ##2
        ref_source_o == (wd_ff[4] ? 2'h2 : {1'b0, wd_ff[3]})) else $error("bad reference");
    a_sensor_power: assert property (wr_ok && avs_address_i == 8'hD1 |-> ##2
        sensor_enable_o == wd_ff[2]) else $error("bad sensor enable");
    a_bypass_follows: assert property (wr_ok && avs_address_i == 8'hC7 |-> ##2
        regulator_bypass_o == wd_ff[6]) else $error("bad bypass");
    a_refctl_unused: assert property (rd_ok && avs_address_i == 8'hD1 |->
        (avs_readdata_o & 8'hE3) == 8'h00) else $error("unused bits read nonzero");
    a_low_unused: assert property (rd_ok && avs_address_i == 8'h85 |->
        avs_readdata_o[5:0] == 6'h00) else $error("low byte unused bits nonzero");
    a_high_read: assert property (rd_ok && avs_address_i == 8'h86 |->
        avs_readdata_o == temp_offset_word_o[9:2]) else $error("high byte mismatch");
    a_off_needs_stop: assert property (regulator_off_o |-> $past(stop_mode_i))
        else $error("regulator off outside stop");
    a_cal_load: assert property (!$past(reset_n_i) |-> ##2
        temp_offset_word_o == $past(cal_word_i, 2)) else $error("offset not loaded");
    cover property (wr_ok && avs_address_i == 8'hD1);
    cover property (rd_ok && avs_address_i == 8'h85);
    cover property (regulator_off_o);
endmodule
bind ref_regulator_ctrl_regs ref_regulator_ctrl_props u_props (.*);

/* tb/tb_ref_regulator_ctrl_regs.sv */
// self-checking bench for the reference and regulator register bank
`timescale 1ns/1ps
module tb_ref_regulator_ctrl_regs;
    reg clk_sys_i = 0, reset_n_i = 0, avs_read_i = 0, avs_write_i = 0, stop_mode_i = 0;
    reg [7:0] avs_address_i = 8'h00, avs_writedata_i = 8'h00, d;
    reg [9:0] cal_word_i = 10'h2B5;
    wire [7:0] avs_readdata_o;
    wire [1:0] ref_source_o;
    wire [9:0] temp_offset_word_o;
    wire avs_waitrequest_o, sensor_enable_o, regulator_bypass_o, regulator_off_o;
    wire mem_power_ctrl_o;
    reg [7:0] exp_q[$];
    reg [31:0] lfsr = 32'h962FC00B;
    int num_errors = 0, cmp_count = 0;
    ref_regulator_ctrl_regs u_dut (.*);
    always #12.5 clk_sys_i = ~clk_sys_i;
////////////////////////////////////////
    task cmp(input [7:0] got, input [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task conclude;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // a read notes its expected data; the watcher checks it at the ack edge
    task bus(input w, input [7:0] a, input [7:0] v);
        int n;
        n = 0;
        if (!w) exp_q.push_back(v);
        @(posedge clk_sys_i);
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_address_i <= a;
        avs_writedata_i <= v;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0 && n++ < 20);
        // a slave that never answers counts against the run
        if (avs_waitrequest_o !== 1'b0) num_errors++;
        avs_write_i <= 0;
        avs_read_i <= 0;
    endtask
    // packed levels: {00, source, sensor, bypass, off, mem power}
    task out(input [7:0] e);
        @(posedge clk_sys_i);
        #1;
        cmp({2'h0, ref_source_o, sensor_enable_o, regulator_bypass_o, regulator_off_o,
            mem_power_ctrl_o}, e);
    endtask
    always @(posedge clk_sys_i)
        if (avs_read_i && avs_waitrequest_o === 1'b0)
            cmp(avs_readdata_o, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    initial begin
        #50us;
        num_errors++;
        conclude;
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        reset_n_i <= 1;
        @(posedge clk_sys_i);
        bus(0, 8'h86, cal_word_i[9:2]);
        bus(0, 8'h85, {cal_word_i[1:0], 6'h00});
        bus(0, 8'hD1, 8'h00);
        bus(0, 8'hC7, 8'h00);
        bus(0, 8'h20, 8'h00); // unmapped place reads zero
        for (int k = 0; k < 8; k++) begin
            lfsr = lfsr_next(lfsr);
            d = {lfsr[7:5], k[2:0], lfsr[1:0]};
            bus(1, 8'hD1, d);
            out({2'h0, k[2] ? 2'h2 : {1'b0, k[1]}, k[0], 3'h0});
            bus(0, 8'hD1, d & 8'h1C);
            bus(1, 8'h85, d);
            bus(1, 8'h86, ~d);
            bus(0, 8'h85, d & 8'hC0);
            cmp(temp_offset_word_o[9:2], ~d);
        end
        bus(1, 8'hC7, 8'hC1);
        out(8'h2D);
        @(posedge clk_sys_i);
        stop_mode_i <= 1;
        out(8'h2F);
        bus(1, 8'hC7, 8'h41);
        out(8'h2D);
        bus(0, 8'hC7, 8'h41);
        conclude;
    end
endmodule
